// [design/csw_ctrl.sv]
// Chip-select and wait controller: block registers on Avalon-MM, external bus
// sequencer with wait states, wait pin and dynamic bus sizing.
// Assumes a 50 MHz clk, an asynchronous active-low reset and a CPU-side
// requester that pulses acc_req only while acc_ready is high.
//
// Contract
// [RULE1] Each block has its own one-byte control register, writable only in system mode.
// [RULE2] Bit 7 enables a block; after reset blocks 0 and 1 are off and block 2 is on.
// [RULE3] Bit 6 at 1 limits a block to system mode, at 0 any mode; it resets to 0.
// [RULE4] Bit 5 selects chip-select waveform at 0 and column-strobe waveform at 1; resets to 0.
// [RULE5] Bit 4 selects the 16-bit data bus at 0 and the 8-bit data bus at 1.
// [RULE6] Wait code 00 gives two wait states, 01 one, 11 none, all ignoring the pin; reset 00.
// [RULE7] Wait code 10 gives one wait state, then holds the cycle while the wait pin is low.
// [RULE8] Window code 00 maps block 0 to 7F00H-7FFFH, block 1 to 480H-7FFFH, block 2 to 8000H-3FFFFFH.
// [RULE9] Window codes 01, 10, 11 map to 400000H, 800000H and C00000H upward in 4 Mbyte windows.
// [RULE10] An 8-bit block moves one byte per access on the low lane, lowest byte first.
// [RULE11] A 16-bit block uses full words when even; an odd start goes high lane, then pairs, then low lane.
// [RULE12] On reads a lane that carries no operand byte is ignored.
// [RULE13] On writes an unused lane is not driven and its write strobe stays inactive.
// [RULE14] Where blocks 0 and 1 overlap, only block 0 takes the access.
// [RULE15] An address no enabled block claims uses the 16-bit bus with no wait states.
// [RULE16] A block claims only when enabled, in its window and allowed in the current mode.
`timescale 1ns/10ps
`include "csw_regs.svh"
module csw_ctrl (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [8:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic cpu_system_mode,
	input wire logic acc_req,
	output logic acc_ready,
	input wire logic [23:0] acc_addr,
	input wire csw_pkg::csw_size_t acc_size,
	input wire logic acc_write,
	input wire logic [31:0] acc_wdata,
	input wire logic acc_system_mode,
	output logic acc_done,
	output logic [31:0] acc_rdata,
	output logic [23:0] ext_addr,
	output logic ext_rd_b,
	output logic ext_wr_lo_b,
	output logic ext_wr_hi_b,
	input wire logic [15:0] ext_data_i,
	output logic [15:0] ext_data_o,
	output logic ext_data_lo_oe,
	output logic ext_data_hi_oe,
	input wire logic ext_wait_b,
	output logic block0_strobe_b,
	output logic block1_strobe_b,
	output logic block2_strobe_b
);
	import csw_pkg::*;

	localparam logic [7:0] RST_VAL [0:2] = '{`CSW_RST_B0, `CSW_RST_B1, `CSW_RST_B2};
	localparam logic [23:0] DEF_LO [0:2] = '{`CSW_B0_LO, `CSW_B1_LO, `CSW_B2_LO};
	localparam logic [23:0] DEF_HI [0:2] = '{`CSW_B0_HI, `CSW_B1_HI, `CSW_B2_HI};
	localparam logic [6:0] BLK_IDX [0:2] = '{`CSW_IDX_B0, `CSW_IDX_B1, `CSW_IDX_B2};

	csw_state_t state_r;
	csw_state_t state_nxt;
	logic [23:0] ext_addr_r;
	logic [31:0] wdata_r;
	logic [2:0] nbytes_r;
	logic [1:0] k_r;
	logic wr_r;
	logic sys_r;
	logic [1:0] wcnt_r;
	logic [7:0] rbyte_r [0:3];
	logic [15:0] data_o_r;
	logic done_r;
	logic ack_r;
	logic [31:0] readdata_r;
	logic wait_s;
	logic [7:0] status;

	logic [2:0] claim;
	logic [2:0] narrow;
	logic [2:0] cas_sel;
	csw_wait_t wcode_b [0:2];
	logic [2:0] we;

	// Register bus decode.
	wire [6:0] reg_idx = avs_address[8:2];
	wire bus_req = avs_read || avs_write;
	wire wr_go = avs_write && ack_r && avs_byteenable[0];
	wire stat_hit = (reg_idx == `CSW_IDX_STAT);

	// Access sequencing.
	wire in_idle = (state_r == CSW_IDLE);
	wire in_setup = (state_r == CSW_SETUP);
	wire in_strobe = (state_r == CSW_STROBE);
	wire take = in_idle && acc_req;

	// Block selection with fixed priority so the overlap goes to block 0.
	wire [2:0] sel = {claim[2] && !claim[1] && !claim[0], claim[1] && !claim[0], claim[0]}; // [RULE14]
	wire narrow_c = |(sel & narrow); // [RULE5] [RULE15]
	wire [2:0] cas_c = sel & cas_sel;
	wire csw_wait_t wcode_c = sel[0] ? wcode_b[0] :
		sel[1] ? wcode_b[1] :
		sel[2] ? wcode_b[2] : CSW_W0; // [RULE15] [RULE16]

	// Lane plan for the piece at the current address.
	wire [2:0] rem = nbytes_r - {1'b0, k_r};
	wire two = !narrow_c && !ext_addr_r[0] && (rem > 3'h1); // [RULE11]
	wire use_hi = !narrow_c && (ext_addr_r[0] || two); // [RULE10] [RULE11]
	wire use_lo = !use_hi || two;
	wire [2:0] nb = two ? 3'h2 : 3'h1;
	wire last = (rem <= nb);
	wire [31:0] shifted = wdata_r >> {k_r, 3'b000};
	wire [7:0] lane_lo = shifted[7:0];
	wire [7:0] lane_hi = two ? shifted[15:8] : shifted[7:0];

	wire pin_hold = (wcode_c == CSW_WPIN) && !wait_s; // [RULE7]
	wire finish = in_strobe && (wcnt_r == 2'h0) && !pin_hold;

	logic [1:0] wload;
	always_comb begin
		unique case (wcode_c)
			CSW_W2: wload = `CSW_WS_TWO; // [RULE6]
			CSW_W1: wload = `CSW_WS_ONE; // [RULE6]
			CSW_WPIN: wload = `CSW_WS_ONE; // [RULE7]
			CSW_W0: wload = `CSW_WS_NONE; // [RULE6]
		endcase
	end

	logic [2:0] size_bytes;
	always_comb begin
		unique case (acc_size)
			CSW_SZ8: size_bytes = 3'h1;
			CSW_SZ16: size_bytes = 3'h2;
			default: size_bytes = 3'h4;
		endcase
	end

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_blk
			assign we[gi] = wr_go && (reg_idx == BLK_IDX[gi]);
			csw_block #(
				.RST_VAL(RST_VAL[gi]),
				.DEF_LO(DEF_LO[gi]),
				.DEF_HI(DEF_HI[gi])
			) u_block (
				.clk(clk),
				.rst_b(rst_b),
				.wr_en(we[gi]),
				.wr_sys(cpu_system_mode),
				.wdata(avs_writedata[7:0]),
				.acc_sys(sys_r),
				.addr(ext_addr_r),
				.claim(claim[gi]),
				.narrow(narrow[gi]),
				.cas_sel(cas_sel[gi]),
				.wait_code(wcode_b[gi])
			);
		end
	endgenerate

	// The wait pin is asynchronous to clk, so it costs two cycles of latency.
	csw_sync #(
		.WIDTH(1),
		.RST_VAL(1'b1)
	) u_wait_sync (
		.clk(clk),
		.rst_b(rst_b),
		.d(ext_wait_b),
		.q(wait_s)
	);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			CSW_IDLE: begin
				if (acc_req) begin
					state_nxt = CSW_SETUP;
				end
			end
			CSW_SETUP: state_nxt = CSW_STROBE;
			CSW_STROBE: begin
				if (finish) begin
					state_nxt = last ? CSW_IDLE : CSW_SETUP; // [RULE10] [RULE11]
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= CSW_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ext_addr_r <= 24'h000000;
			k_r <= 2'h0;
		end else if (take) begin
			ext_addr_r <= acc_addr;
			k_r <= 2'h0;
		end else if (finish) begin
			ext_addr_r <= ext_addr_r + {21'h000000, nb}; // [RULE10] [RULE11]
			k_r <= k_r + nb[1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wdata_r <= 32'h00000000;
			nbytes_r <= 3'h1;
			wr_r <= 1'b0;
			sys_r <= 1'b0;
		end else if (take) begin
			wdata_r <= acc_wdata;
			nbytes_r <= size_bytes;
			wr_r <= acc_write;
			sys_r <= acc_system_mode;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wcnt_r <= 2'h0;
			data_o_r <= 16'h0000;
		end else if (in_setup) begin
			wcnt_r <= wload;
			data_o_r <= {lane_hi, lane_lo};
		end else if (in_strobe && (wcnt_r != 2'h0)) begin
			wcnt_r <= wcnt_r - 2'h1;
		end
	end

	// Read capture keeps only the lanes that carry operand bytes.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 4; i++) begin
				rbyte_r[i] <= 8'h00;
			end
		end else if (take) begin
			for (int i = 0; i < 4; i++) begin
				rbyte_r[i] <= 8'h00;
			end
		end else if (finish && !wr_r) begin
			if (two) begin
				rbyte_r[k_r] <= ext_data_i[7:0];
				rbyte_r[k_r + 2'h1] <= ext_data_i[15:8];
			end else begin
				rbyte_r[k_r] <= use_hi ? ext_data_i[15:8] : ext_data_i[7:0]; // [RULE12]
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			done_r <= 1'b0;
		end else begin
			done_r <= finish && last;
		end
	end

	// Every bus access waits exactly one cycle, which keeps the read mux off the
	// combinational path from the address pins.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_r <= 1'b0;
			readdata_r <= 32'h00000000;
		end else begin
			ack_r <= bus_req && !ack_r;
			if (avs_read && !ack_r) begin
				readdata_r <= stat_hit ? {24'h000000, status} : 32'h00000000;
			end
		end
	end

	assign status = {1'b0, wait_s, k_r, sel & {3{!in_idle}}, !in_idle};

	assign avs_waitrequest = bus_req && !ack_r;
	assign avs_readdata = readdata_r;
	assign acc_ready = in_idle;
	assign acc_done = done_r;
	assign acc_rdata = {rbyte_r[3], rbyte_r[2], rbyte_r[1], rbyte_r[0]};

	assign ext_addr = ext_addr_r;
	assign ext_data_o = data_o_r;
	assign ext_rd_b = !(in_strobe && !wr_r);
	assign ext_wr_lo_b = !(in_strobe && wr_r && use_lo); // [RULE13]
	assign ext_wr_hi_b = !(in_strobe && wr_r && use_hi); // [RULE13]
	assign ext_data_lo_oe = in_strobe && wr_r && use_lo; // [RULE13]
	assign ext_data_hi_oe = in_strobe && wr_r && use_hi; // [RULE13]

	// Chip-select spans setup and strobe; column strobe only the strobe phase.
	wire [2:0] strobe_on = sel & ((cas_c & {3{in_strobe}}) | (~cas_c & {3{in_setup || in_strobe}})); // [RULE4]
	assign block0_strobe_b = !strobe_on[0]; // [RULE9]
	assign block1_strobe_b = !strobe_on[1];
	assign block2_strobe_b = !strobe_on[2];
endmodule

// [design/csw_regs.svh]
// Register indices, field positions, reset values and timing counts of the
// chip-select and wait controller. Definitions only; included by the csw_ctrl and csw_block modules.
`ifndef CSW_REGS_SVH
`define CSW_REGS_SVH

// Register indices; the Avalon byte address is four times the index.
`define CSW_IDX_B0 7'h68
`define CSW_IDX_B1 7'h69
`define CSW_IDX_B2 7'h6A
`define CSW_IDX_STAT 7'h6B

// Reset values of the block control registers.
`define CSW_RST_B0 8'h00
`define CSW_RST_B1 8'h00
`define CSW_RST_B2 8'h80

// Field positions inside a block control register.
`define CSW_BIT_EN 7
`define CSW_BIT_SYS 6
`define CSW_BIT_CAS 5
`define CSW_BIT_BUS 4
`define CSW_BIT_W_HI 3
`define CSW_BIT_W_LO 2
`define CSW_BIT_C_HI 1
`define CSW_BIT_C_LO 0

// Default windows used with window code 00.
`define CSW_B0_LO 24'h007F00
`define CSW_B0_HI 24'h007FFF
`define CSW_B1_LO 24'h000480
`define CSW_B1_HI 24'h007FFF
`define CSW_B2_LO 24'h008000
`define CSW_B2_HI 24'h3FFFFF

// Wait states inserted per wait policy code, in bus clock cycles.
`define CSW_WS_TWO 2'h2
`define CSW_WS_ONE 2'h1
`define CSW_WS_NONE 2'h0

`endif

// [design/csw_pkg.sv]
// Types shared by the chip-select and wait controller modules.
// Assumes nothing of its surroundings.
package csw_pkg;

	typedef enum logic [2:0] {
		CSW_IDLE = 3'b001,
		CSW_SETUP = 3'b010,
		CSW_STROBE = 3'b100
	} csw_state_t;

	typedef enum logic [1:0] {
		CSW_W2 = 2'h0,
		CSW_W1 = 2'h1,
		CSW_WPIN = 2'h2,
		CSW_W0 = 2'h3
	} csw_wait_t;

	typedef enum logic [1:0] {
		CSW_SZ8 = 2'h0,
		CSW_SZ16 = 2'h1,
		CSW_SZ32 = 2'h2
	} csw_size_t;

endpackage

// [design/csw_sync.sv]
// Two-stage synchroniser for a level arriving from outside the clock domain.
// Assumes the input is a slow level; a pulse shorter than one cycle may be missed.
`timescale 1ns/10ps
module csw_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// [design/csw_block.sv]
// One block area: its write-only control register and its address window match.
// Assumes the write strobe is already decoded and qualified by the bus slave.
`timescale 1ns/10ps
`include "csw_regs.svh"
module csw_block #(
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter logic [23:0] DEF_LO = 24'h000000,
	parameter logic [23:0] DEF_HI = 24'h000000
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic wr_sys,
	input wire logic [7:0] wdata,
	input wire logic acc_sys,
	input wire logic [23:0] addr,
	output logic claim,
	output logic narrow,
	output logic cas_sel,
	output csw_pkg::csw_wait_t wait_code
);
	import csw_pkg::*;

	logic [7:0] ctrl_r;
	logic [1:0] win;
	logic in_def;
	logic in_win;
	logic mode_ok;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r <= RST_VAL; // [RULE2] [RULE3] [RULE4] [RULE6]
		end else if (wr_en && wr_sys) begin
			ctrl_r <= wdata; // [RULE1]
		end
	end

	assign win = ctrl_r[`CSW_BIT_C_HI:`CSW_BIT_C_LO];
	assign in_def = (addr >= DEF_LO) && (addr <= DEF_HI); // [RULE8]
	// Codes 01 to 11 coincide with the top two address bits of their window.
	assign in_win = (win == 2'h0) ? in_def : (addr[23:22] == win); // [RULE9]
	assign mode_ok = !ctrl_r[`CSW_BIT_SYS] || acc_sys; // [RULE3]
	assign claim = ctrl_r[`CSW_BIT_EN] && in_win && mode_ok; // [RULE2] [RULE16]
	assign narrow = ctrl_r[`CSW_BIT_BUS]; // [RULE5]
	assign cas_sel = ctrl_r[`CSW_BIT_CAS]; // [RULE4]
	assign wait_code = csw_wait_t'(ctrl_r[`CSW_BIT_W_HI:`CSW_BIT_W_LO]); // [RULE6]
endmodule

// [testbench/csw_ctrl_checker.sv]
// Port checker for the chip-select and wait controller.
// Assumes one clock domain and the active-low reset of the bound design.
`timescale 1ns/10ps
module csw_ctrl_checker (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [8:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic acc_req,
	input wire logic acc_ready,
	input wire logic acc_done,
	input wire logic [23:0] ext_addr,
	input wire logic ext_rd_b,
	input wire logic ext_wr_lo_b,
	input wire logic ext_wr_hi_b,
	input wire logic ext_data_lo_oe,
	input wire logic ext_data_hi_oe,
	input wire logic block0_strobe_b,
	input wire logic block1_strobe_b,
	input wire logic block2_strobe_b
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	AST_REG_ACK: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("register access not answered");
	AST_WO_READ: assert property (avs_read && !avs_waitrequest
		&& avs_address[8:2] inside {7'h68, 7'h69, 7'h6A} |-> avs_readdata == 32'h0)
		else $error("control register read not zero");
	AST_LANE_LO: assert property (!ext_data_lo_oe |-> ext_wr_lo_b)
		else $error("low lane strobe without drive");
	AST_LANE_HI: assert property (!ext_data_hi_oe |-> ext_wr_hi_b)
		else $error("high lane strobe without drive");
	AST_ODD_ONE_LANE: assert property (ext_addr[0] |-> ext_wr_lo_b || ext_wr_hi_b)
		else $error("both lanes written at odd address");
	AST_READ_QUIET: assert property (!ext_rd_b |-> ext_wr_lo_b && ext_wr_hi_b
		&& !ext_data_lo_oe && !ext_data_hi_oe)
		else $error("lane driven during read");
	AST_ONE_BLOCK: assert property ($onehot0({!block0_strobe_b, !block1_strobe_b,
		!block2_strobe_b}))
		else $error("two block strobes low");
	AST_MIN_CYCLE: assert property (acc_req && acc_ready |=> !acc_done [*2])
		else $error("access finished too early");
	AST_IDLE_QUIET: assert property (acc_ready |-> block0_strobe_b && block1_strobe_b
		&& block2_strobe_b && ext_rd_b && ext_wr_lo_b && ext_wr_hi_b)
		else $error("strobe low while idle");
endmodule

bind csw_ctrl csw_ctrl_checker chk_i (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .acc_req(acc_req), .acc_ready(acc_ready),
	.acc_done(acc_done), .ext_addr(ext_addr), .ext_rd_b(ext_rd_b), .ext_wr_lo_b(ext_wr_lo_b),
	.ext_wr_hi_b(ext_wr_hi_b), .ext_data_lo_oe(ext_data_lo_oe),
	.ext_data_hi_oe(ext_data_hi_oe), .block0_strobe_b(block0_strobe_b),
	.block1_strobe_b(block1_strobe_b), .block2_strobe_b(block2_strobe_b));

// [testbench/csw_mem.sv]
// Behavioural external memory and wait source on the controller's far side.
// Assumes a synchronous bus: read data are taken at the edge ending the strobe.
`timescale 1ns/10ps
module csw_mem (
	input wire logic clk,
	input wire logic [23:0] ext_addr,
	input wire logic ext_rd_b,
	input wire logic ext_wr_lo_b,
	input wire logic ext_wr_hi_b,
	input wire logic cs_b,
	input wire logic [15:0] ext_data_o,
	input wire logic [7:0] stall,
	output logic [15:0] ext_data_i,
	output logic ext_wait_b
);
	logic [7:0] mem [256];
	logic [15:0] last_r = 16'hA5C3;
	logic [7:0] cnt_r = 8'h00;
	wire logic [7:0] a_even = {ext_addr[7:1], 1'b0};
	// The wait pin falls with the block select, as the controller sees it two cycles late.
	wire logic busy = !cs_b || !ext_rd_b || !ext_wr_lo_b || !ext_wr_hi_b;
	// The low lane carries the addressed byte, so byte-wide parts at odd addresses fit too.
	// A released bus shows the inverse of its last value, so stale data never match.
	assign ext_data_i = !ext_rd_b ? {mem[a_even + 8'h01], mem[ext_addr[7:0]]} : ~last_r;
	// The wait pin is held low for stall cycles of an access, then released high.
	assign ext_wait_b = !(busy && cnt_r != stall);
	always @(posedge clk) begin
		cnt_r <= busy ? cnt_r + {7'h00, cnt_r != stall} : 8'h00;
		if (!ext_rd_b) last_r <= ext_data_i;
		if (!ext_wr_lo_b) mem[ext_addr[7:0]] <= ext_data_o[7:0];
		if (!ext_wr_hi_b) mem[a_even + 8'h01] <= ext_data_o[15:8];
	end
endmodule

// [testbench/tb_top.sv]
// Testbench of the chip-select and wait controller with an external memory model.
// Assumes the controller, its package and the checker are compiled before it.
`timescale 1ns/10ps
module tb_top;
	import csw_pkg::*;
	logic clk = 0, rst_b = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
	logic cpu_system_mode = 1, acc_req = 0, acc_ready, acc_write = 0, acc_system_mode = 0;
	logic acc_done, ext_rd_b, ext_wr_lo_b, ext_wr_hi_b, ext_data_lo_oe, ext_data_hi_oe;
	logic ext_wait_b, block0_strobe_b, block1_strobe_b, block2_strobe_b;
	logic [8:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, acc_wdata = 0, acc_rdata, r, rdat, cyc, lows;
	logic [23:0] acc_addr = 0, ext_addr;
	logic [15:0] ext_data_i, ext_data_o;
	logic [7:0] stall = 0;
	logic [2:0] seen;
	csw_size_t acc_size = CSW_SZ8;
	int n_fail = 0, comparisons = 0, i;
	csw_ctrl uut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.cpu_system_mode(cpu_system_mode), .acc_req(acc_req), .acc_ready(acc_ready),
		.acc_addr(acc_addr), .acc_size(acc_size), .acc_write(acc_write), .acc_wdata(acc_wdata),
		.acc_system_mode(acc_system_mode), .acc_done(acc_done), .acc_rdata(acc_rdata),
		.ext_addr(ext_addr), .ext_rd_b(ext_rd_b), .ext_wr_lo_b(ext_wr_lo_b),
		.ext_wr_hi_b(ext_wr_hi_b), .ext_data_i(ext_data_i), .ext_data_o(ext_data_o),
		.ext_data_lo_oe(ext_data_lo_oe), .ext_data_hi_oe(ext_data_hi_oe),
		.ext_wait_b(ext_wait_b), .block0_strobe_b(block0_strobe_b),
		.block1_strobe_b(block1_strobe_b), .block2_strobe_b(block2_strobe_b));
	csw_mem ext_mem (.clk(clk), .ext_addr(ext_addr), .ext_rd_b(ext_rd_b),
		.cs_b(block0_strobe_b && block1_strobe_b && block2_strobe_b),
		.ext_wr_lo_b(ext_wr_lo_b), .ext_wr_hi_b(ext_wr_hi_b), .ext_data_o(ext_data_o),
		.stall(stall), .ext_data_i(ext_data_i), .ext_wait_b(ext_wait_b));
	always #10 clk = ~clk;
	task stop_test;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task chk(input string n, input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task avb(input logic w, input logic [6:0] x, input logic [7:0] d, input logic m);
		int k;
		k = 0;
		@(posedge clk);
		avs_address <= {x, 2'b00};
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		cpu_system_mode <= m;
		do begin
			@(posedge clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		if (avs_waitrequest !== 1'b0) n_fail++;
		r = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task acc(input logic [23:0] a, input csw_size_t s, input logic w, input logic [31:0] d,
		input logic m);
		@(posedge clk);
		acc_req <= 1'b1;
		acc_addr <= a;
		acc_size <= s;
		acc_write <= w;
		acc_wdata <= d;
		acc_system_mode <= m;
		do begin
			@(posedge clk);
		end while (acc_ready !== 1'b1);
		acc_req <= 1'b0;
		cyc = 0;
		lows = 0;
		seen = 3'b000;
		do begin
			@(posedge clk);
			cyc++;
			seen |= ~{block2_strobe_b, block1_strobe_b, block0_strobe_b};
			if (!(block0_strobe_b && block1_strobe_b && block2_strobe_b)) lows++;
		end while (acc_done !== 1'b1 && cyc < 100);
		if (acc_done !== 1'b1) n_fail++;
		rdat = acc_rdata;
	endtask
	// The bound covers every scenario with wide margin; a hang ends here.
	initial begin
		#400000;
		n_fail++;
		stop_test();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		avb(0, 7'h6A, 0, 1); chk("ctrl_read", r, 0);
		avb(0, 7'h10, 0, 1); chk("unmapped", r, 0);
		acc(24'h008000, CSW_SZ16, 1, 32'hBEEF, 1); chk("b2_reset", cyc, 5);
		chk("b2_seen", seen, 3'b100);
		acc(24'h007F00, CSW_SZ16, 0, 0, 1); chk("b0_off", seen, 0);
		acc(24'h008000, CSW_SZ16, 0, 0, 1); chk("rd16", rdat, 32'hBEEF);
		avb(1, 7'h6A, 8'h9C, 0); acc(24'h008000, CSW_SZ16, 1, 0, 1);
		chk("normal_wr", cyc, 5);
		for (i = 0; i < 4; i++) begin
			avb(1, 7'h6A, 8'h80 | (i[7:0] << 2), 1); acc(24'h008000, CSW_SZ16, 1, 0, 1);
			chk("wait", cyc, 3 + (i == 3 ? 0 : (i == 0 ? 2 : 1)));
		end
		avb(1, 7'h6A, 8'h88, 1); stall <= 8'h04; acc(24'h008000, CSW_SZ16, 0, 0, 1);
		chk("wait_pin", cyc > 4 && cyc < 14, 1);
		stall <= 8'h00;
		avb(1, 7'h6A, 8'h9C, 1); acc(24'h008000, CSW_SZ32, 1, 32'h44332211, 1);
		chk("narrow_cyc", cyc, 9); chk("lsb_first", ext_mem.mem[0], 8'h11);
		acc(24'h008000, CSW_SZ32, 0, 0, 1); chk("narrow_rd", rdat, 32'h44332211);
		avb(1, 7'h6A, 8'h8C, 1); acc(24'h008001, CSW_SZ32, 1, 32'hDDCCBBAA, 1);
		chk("odd_cyc", cyc, 7); chk("odd_hi", ext_mem.mem[1], 8'hAA);
		acc(24'h008001, CSW_SZ32, 0, 0, 1); chk("odd_rd", rdat, 32'hDDCCBBAA);
		acc(24'h008000, CSW_SZ32, 0, 0, 1); chk("even_cyc", cyc, 5);
		chk("even_rd", rdat, 32'hCCBBAA11);
		avb(1, 7'h6A, 8'hCC, 1); acc(24'h008000, CSW_SZ16, 1, 0, 0);
		chk("sys_normal", seen, 0);
		acc(24'h008000, CSW_SZ16, 1, 0, 1); chk("sys_sys", seen, 3'b100);
		avb(1, 7'h6A, 8'hAC, 1); acc(24'h008000, CSW_SZ16, 1, 0, 1); chk("cas", lows, 1);
		avb(1, 7'h6A, 8'h8C, 1); acc(24'h008000, CSW_SZ16, 1, 0, 1); chk("cs", lows, 2);
		for (i = 1; i < 4; i++) begin
			avb(1, 7'h68, 8'h8C | i[7:0], 1); acc({i[1:0], 22'h0}, CSW_SZ8, 0, 0, 1);
			chk("window", seen, 3'b001);
		end
		avb(1, 7'h68, 8'h8C, 1); avb(1, 7'h69, 8'h80, 1);
		acc(24'h007F00, CSW_SZ8, 0, 0, 1); chk("overlap", seen, 3'b001);
		acc(24'h007EFF, CSW_SZ8, 0, 0, 1); chk("b1_cyc", cyc, 5);
		chk("b1_seen", seen, 3'b010);
		acc(24'h000480, CSW_SZ8, 0, 0, 1); chk("b1_lo", seen, 3'b010);
		acc(24'h3FFFFF, CSW_SZ8, 0, 0, 1); chk("b2_hi", seen, 3'b100);
		acc(24'h00047F, CSW_SZ8, 0, 0, 1); chk("free_cyc", cyc, 3);
		chk("free_seen", seen, 0);
		stop_test();
	end
endmodule
